// ---- flash_spm_pkg.sv ----
// Constants, states and carriers shared by the self-program sequencer.
package flash_spm_pkg;

  // ==========================================================================
  // Control register layout
  localparam int         BIT_IRQ_EN = 7;
  localparam int         BIT_SRE    = 4;
  localparam int         BIT_LOCK   = 3;
  localparam int         BIT_PGW    = 2;
  localparam int         BIT_PGE    = 1;
  localparam int         BIT_SPE    = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h9F;
  localparam logic [7:0] KEEP_MASK  = 8'h80;
  localparam logic [4:0] CMD_MASK   = 5'h1F;

  // ==========================================================================
  // Command patterns in the low five control bits
  localparam logic [4:0] PAT_ERASE = 5'h03;
  localparam logic [4:0] PAT_LOAD  = 5'h01;
  localparam logic [4:0] PAT_WRITE = 5'h05;
  localparam logic [4:0] PAT_FUSE  = 5'h09;

  // ==========================================================================
  // Timing windows in clock cycles after the control write
  localparam logic [2:0] SPM_WIN = 3'h4;
  localparam logic [2:0] LPM_WIN = 3'h3;

  // ==========================================================================
  // Pointer values for fuse and lock reads
  localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] Z_LOCK     = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  localparam logic [15:0] BUF_ERASED  = 16'hFFFF;
  localparam logic [7:0]  BYTE_ONES   = 8'hFF;

  // ==========================================================================
  // Sequencer states, Gray coded along idle, armed, busy
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_BUSY  = 2'b11
  } seq_state_e;

  // Requests from the processor core.
  typedef struct packed {
    logic        ctrl_wr;
    logic [7:0]  ctrl_wdata;
    logic        spm;
    logic        lpm;
    logic [15:0] zptr;
    logic [15:0] data;
  } core_req_s;

  // Stored fuse and lock bits, one means programmed.
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] ext;
    logic [7:0] lock;
  } fuse_bits_s;

endpackage

// ---- flash_self_program_sequencer.sv ----
// Self-program sequencer: command arming, page buffer, erase/write and fuse reads.
`timescale 1ns/1ps
// How it works
// - Erase pattern then store within four cycles
// - Core stalled for the whole erase
// - Load pattern stores one word at pointer
// - Buffer cleared after write, enable bit, reset
// - Data memory write discards loaded buffer
// - Write pattern programs buffer into page
// - Core stalled for the whole page write
// - Buffer words load in any order
// - Low bits word, high bits page
// - Store accepted from any code address
// - Data memory write blocks programming and reads
// - Pointer one returns lock bits
// - Read arming self-clears on completion or timeout
// - Unarmed load reads flash normally
// - Pointer zero returns fuse low byte
// - Pointer three returns fuse high byte
// - Pointer two returns extended fuse byte
// - Programmed reads zero, unprogrammed reads one
// - Ready interrupt while enable bit clear
// - Ready interrupt suppressed during busy writes
module flash_self_program_sequencer #(
  parameter int WORD_BITS = 5
) (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire flash_spm_pkg::core_req_s   core,
  input  wire logic                       global_irq_en,
  input  wire logic                       data_mem_write_busy_bit,
  input  wire flash_spm_pkg::fuse_bits_s  fuses,
  input  wire logic                       flash_done,
  input  wire logic [WORD_BITS-1:0]       buf_rd_idx,
  output logic [7:0]                      prog_mem_ctrl_status,
  output logic                            core_stall,
  output logic                            fuse_rd_valid,
  output logic [7:0]                      fuse_rd_data,
  output logic                            flash_start,
  output logic                            flash_erase,
  output logic [14-WORD_BITS:0]           flash_page,
  output logic [15:0]                     buf_rd_data,
  output logic                            prog_ready_irq
);
  import flash_spm_pkg::*;

  localparam int WORDS = 1 << WORD_BITS;

  // ==========================================================================
  // Parameter check
  // The word field sits above the byte bit, so at most fourteen bits fit.
  if (WORD_BITS < 1 || WORD_BITS > 14) begin : g_bad
    $error("WORD_BITS must lie between 1 and 14");
  end

  // Fuse byte chosen by pointer, inverted so programmed bits read zero.
  function automatic logic [7:0] fuse_pick(input logic [15:0] z, input fuse_bits_s f);
    logic [7:0] v;
    v = BYTE_ONES;
    if (z == Z_FUSE_LOW) begin
      v = f.low;
    end else if (z == Z_LOCK) begin
      v = f.lock;
    end else if (z == Z_FUSE_EXT) begin
      v = f.ext;
    end else if (z == Z_FUSE_HIGH) begin
      v = f.high;
    end
    return ~v;
  endfunction

  // ==========================================================================
  // Sequencer state
  seq_state_e                 st_q, st_d;
  logic [7:0]                 ctrl_q, ctrl_d;
  logic [2:0]                 cnt_q, cnt_d;
  logic                       start_q, start_d;
  logic                       erase_q, erase_d;
  logic [14-WORD_BITS:0]      page_q, page_d;
  logic                       stall_q, stall_d;
  logic                       fv_q, fv_d;
  logic [7:0]                 fd_q, fd_d;
  logic                       irq_q, irq_d;
  logic                       buf_clr;
  logic                       buf_ld;
  logic [4:0]                 cmd;
  logic                       ee;
  logic [WORD_BITS-1:0]       zword;
  logic [14-WORD_BITS:0]      zpage;

  assign ee    = data_mem_write_busy_bit;
  assign cmd   = ctrl_q[4:0] & CMD_MASK;
  // Byte bit dropped, low bits word, upper bits page
  assign zword = core.zptr[WORD_BITS:1];
  assign zpage = core.zptr[15:WORD_BITS+1];

  // Next-state logic for arming, commands and fuse reads.
  always_comb begin
    st_d    = st_q;
    ctrl_d  = ctrl_q;
    cnt_d   = cnt_q;
    start_d = 1'b0;
    erase_d = erase_q;
    page_d  = page_q;
    stall_d = stall_q;
    fv_d    = 1'b0;
    fd_d    = fd_q;
    buf_clr = 1'b0;
    buf_ld  = 1'b0;
    case (st_q)
      ST_IDLE: begin
        // Control writes ignored while data memory busy
        if (core.ctrl_wr && !ee) begin
          ctrl_d = core.ctrl_wdata & CTRL_WMASK;
          if (core.ctrl_wdata[BIT_SRE]) begin
            buf_clr = 1'b1;
            // Only the interrupt enable bit written with this value is kept as written.
            ctrl_d  = core.ctrl_wdata & KEEP_MASK;
          end else if (core.ctrl_wdata[BIT_SPE]) begin
            st_d  = ST_ARMED;
            cnt_d = '0;
          end
        end
      end
      ST_ARMED: begin
        cnt_d = cnt_q + 3'h1;
        // No address region check on the store
        if (core.spm && !ee) begin
          st_d   = ST_IDLE;
          ctrl_d = ctrl_q & KEEP_MASK;
          // Page erase from page field only
          if (cmd == PAT_ERASE) begin
            st_d    = ST_BUSY;
            ctrl_d  = ctrl_q;
            start_d = 1'b1;
            erase_d = 1'b1;
            page_d  = zpage;
            stall_d = 1'b1;
          end else if (cmd == PAT_WRITE) begin
            st_d    = ST_BUSY;
            ctrl_d  = ctrl_q;
            start_d = 1'b1;
            erase_d = 1'b0;
            page_d  = zpage;
            stall_d = 1'b1;
          end else if (cmd == PAT_LOAD) begin
            buf_ld = 1'b1;
          end
        // Only armed fuse reads divert loads
        end else if (core.lpm && cnt_q < LPM_WIN && cmd == PAT_FUSE && !ee) begin
          st_d   = ST_IDLE;
          ctrl_d = ctrl_q & KEEP_MASK;
          fv_d   = 1'b1;
          fd_d   = fuse_pick(core.zptr, fuses);
        end else if (cnt_q == SPM_WIN - 3'h1) begin
          st_d   = ST_IDLE;
          ctrl_d = ctrl_q & KEEP_MASK;
        end
      end
      ST_BUSY: begin
        if (flash_done) begin
          st_d    = ST_IDLE;
          stall_d = 1'b0;
          ctrl_d  = ctrl_q & KEEP_MASK;
          // Buffer cleared after a page write
          buf_clr = !erase_q;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // Suppressed during data memory write or store
    irq_d = ctrl_q[BIT_IRQ_EN] && global_irq_en && !ctrl_q[BIT_SPE]
            && !ee && st_q != ST_BUSY;
  end

  // Sequencer registers.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= ST_IDLE;
      ctrl_q  <= CTRL_RESET;
      cnt_q   <= '0;
      start_q <= 1'b0;
      erase_q <= 1'b0;
      page_q  <= '0;
      stall_q <= 1'b0;
      fv_q    <= 1'b0;
      fd_q    <= '0;
      irq_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      ctrl_q  <= ctrl_d;
      cnt_q   <= cnt_d;
      start_q <= start_d;
      erase_q <= erase_d;
      page_q  <= page_d;
      stall_q <= stall_d;
      fv_q    <= fv_d;
      fd_q    <= fd_d;
      irq_q   <= irq_d;
    end
  end

  // ==========================================================================
  // Temporary page buffer
  // Valid bits give a one-cycle clear of the whole page; data is left stale.
  logic [15:0]      mem_q [WORDS];
  logic [WORDS-1:0] val_q, val_d;
  logic [15:0]      rd_q, rd_d;

  // Any word position may be loaded in any order
  for (genvar i = 0; i < WORDS; i++) begin : g_val
    always_comb begin
      val_d[i] = val_q[i];
      // Data memory write discards the loaded words
      if (buf_clr || ee) begin
        val_d[i] = 1'b0;
      end else if (buf_ld && zword == WORD_BITS'(i)) begin
        val_d[i] = 1'b1;
      end
    end
  end

  // Unloaded words read as erased flash.
  always_comb begin
    rd_d = val_q[buf_rd_idx] ? mem_q[buf_rd_idx] : BUF_ERASED;
  end

  // The data array has no reset; only the valid bits need one.
  always_ff @(posedge clk) begin
    if (buf_ld) begin
      mem_q[zword] <= core.data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      val_q <= '0;
      rd_q  <= BUF_ERASED;
    end else begin
      val_q <= val_d;
      rd_q  <= rd_d;
    end
  end

  // Outputs straight from flip-flops.
  assign prog_mem_ctrl_status = ctrl_q;
  assign core_stall           = stall_q;
  assign fuse_rd_valid        = fv_q;
  assign fuse_rd_data         = fd_q;
  assign flash_start          = start_q;
  assign flash_erase          = erase_q;
  assign flash_page           = page_q;
  assign buf_rd_data          = rd_q;
  assign prog_ready_irq       = irq_q;

  // ==========================================================================
  // Assertions
  logic [WORD_BITS-1:0]  zword_q;
  logic [14-WORD_BITS:0] zpage_q;
  logic                  ld_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      zword_q <= '0;
      zpage_q <= '0;
      ld_q    <= 1'b0;
    end else begin
      zword_q <= zword;
      zpage_q <= zpage;
      ld_q    <= buf_ld && !ee;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_erase_start: assert property (flash_start && flash_erase |->
    $past(st_q) == ST_ARMED && $past(cmd) == PAT_ERASE) else $error("bad erase start");
  chk_stall_start: assert property ($rose(flash_start) |-> core_stall
    ##1 core_stall) else $error("core not stalled");
  chk_load_word: assert property (ld_q |-> val_q[zword_q])
    else $error("buffer word not loaded");
  chk_write_clear: assert property (st_q == ST_BUSY && flash_done && !flash_erase
    |=> val_q == '0) else $error("buffer kept after write");
  chk_ee_discard: assert property (ee |=> val_q == '0)
    else $error("buffer kept during data write");
  chk_stall_end: assert property (st_q == ST_BUSY && flash_done |=> !core_stall)
    else $error("stall not released");
  chk_page_split: assert property (flash_start |-> flash_page == $past(zpage))
    else $error("wrong page address");
  chk_ee_block: assert property (ee && st_q == ST_IDLE |=> st_q == ST_IDLE)
    else $error("armed during data write");
  chk_arm_window: assert property ($rose(st_q == ST_ARMED) |->
    ##[1:4] st_q != ST_ARMED) else $error("arming outlived window");
  chk_plain_read: assert property (core.lpm && !ctrl_q[BIT_LOCK] |=> !fuse_rd_valid)
    else $error("fuse read without arming");
  chk_irq_quiet: assert property (ee |=> !prog_ready_irq)
    else $error("interrupt during data write");

  cov_erase: cover property (flash_start && flash_erase ##[1:20] flash_done);
  cov_load: cover property (ld_q);
  cov_fuse: cover property (fuse_rd_valid);
  cov_timeout: cover property (st_q == ST_ARMED ##1 st_q == ST_ARMED [*3] ##1 st_q == ST_IDLE);

endmodule

// ---- flash_macro_model.sv ----
// Behavioural flash macro: answers each start with one done pulse after a delay.
`timescale 1ns/1ps
module flash_macro_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       flash_start,
  input  wire logic [7:0] busy_cycles,
  output logic            flash_done
);
  logic [8:0] left_q;
  // ==========================================================================
  // Busy countdown
  // One operation at a time; a start while counting would restart the count.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_q     <= 9'h000;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (left_q == 9'h001);
      if (flash_start) begin
        left_q <= {1'b0, busy_cycles} + 9'h001;
      end else if (left_q != 9'h000) begin
        left_q <= left_q - 9'h001;
      end
    end
  end
endmodule

// ---- test_flash_self_program_sequencer.sv ----
// Self-checking bench for the self-program sequencer.
`timescale 1ns/1ps
module test_flash_self_program_sequencer;
  import flash_spm_pkg::*;
  localparam int WB = 2;
  logic            clk = 1'b0;
  logic            resetn;
  core_req_s       req;
  logic            global_irq_en;
  logic            data_mem_write_busy_bit;
  fuse_bits_s      fuses;
  logic            flash_done;
  logic [WB-1:0]   buf_rd_idx;
  logic [7:0]      status;
  logic            core_stall;
  logic            fuse_rd_valid;
  logic [7:0]      fuse_rd_data;
  logic            flash_start;
  logic            flash_erase;
  logic [14-WB:0]  flash_page;
  logic [15:0]     buf_rd_data;
  logic            prog_ready_irq;
  logic [7:0]      busy_cycles;
  logic [15:0]     exp_q[$];
  logic [15:0]     e;
  logic [15:0]     w[4];
  logic [14-WB:0]  pg;
  int              n_errors = 0;
  int              n_checks = 0;
  int              cycles = 0;
  int              seed = 52843;
  int              i;

  always #2 clk = ~clk;

  flash_self_program_sequencer #(.WORD_BITS(WB)) u_flash_self_program_sequencer (
    .clk(clk), .resetn(resetn), .core(req), .global_irq_en(global_irq_en),
    .data_mem_write_busy_bit(data_mem_write_busy_bit), .fuses(fuses),
    .flash_done(flash_done), .buf_rd_idx(buf_rd_idx), .prog_mem_ctrl_status(status),
    .core_stall(core_stall), .fuse_rd_valid(fuse_rd_valid), .fuse_rd_data(fuse_rd_data),
    .flash_start(flash_start), .flash_erase(flash_erase), .flash_page(flash_page),
    .buf_rd_data(buf_rd_data), .prog_ready_irq(prog_ready_irq));

  flash_macro_model u_flash_macro_model (
    .clk(clk), .resetn(resetn), .flash_start(flash_start),
    .busy_cycles(busy_cycles), .flash_done(flash_done));

  // ==========================================================================
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    n_checks++;
    if (seen !== expv) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic print_verdict;
    $display("errors=%0d checks=%0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Inputs always move 1 ns after the rising edge.
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask

  task automatic wr_ctrl(input logic [7:0] v);
    req.ctrl_wr = 1'b1;
    req.ctrl_wdata = v;
    cyc;
    req.ctrl_wr = 1'b0;
  endtask

  task automatic spm(input logic [15:0] z, input logic [15:0] d);
    req.spm = 1'b1;
    req.zptr = z;
    req.data = d;
    cyc;
    req.spm = 1'b0;
  endtask

  task automatic lpm(input logic [15:0] z);
    req.lpm = 1'b1;
    req.zptr = z;
    cyc;
    req.lpm = 1'b0;
  endtask

  task automatic bufchk(input int idx, input logic [15:0] expv);
    buf_rd_idx = WB'(idx);
    cyc;
    check(buf_rd_data, expv);
  endtask

  // Waits, bounded, for the core to be released after an erase or write.
  task automatic wait_idle;
    for (int k = 0; k < 300 && core_stall === 1'b1; k++) begin
      cyc;
    end
    check(16'(core_stall), 16'h0000);
  endtask

  task automatic load(input int idx, input logic [15:0] d, input int gap);
    wr_ctrl(8'h01);
    repeat (gap) cyc;
    spm({pg, 2'(idx), 1'b0}, d);
  endtask

  function automatic logic [7:0] fuse_exp(input int z);
    case (z)
      0: return ~fuses.low;
      1: return ~fuses.lock;
      2: return ~fuses.ext;
      3: return ~fuses.high;
      default: return 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // Watcher: every fuse byte or flash start must match the oldest note.
  always @(posedge clk) begin
    if (resetn && (fuse_rd_valid === 1'b1 || flash_start === 1'b1)) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
      if (flash_start === 1'b1) begin
        check({2'b00, flash_erase, flash_page}, e);
      end else begin
        check({8'h00, fuse_rd_data}, e);
      end
    end
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict;
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    req = '0;
    global_irq_en = 1'b0;
    data_mem_write_busy_bit = 1'b0;
    buf_rd_idx = '0;
    busy_cycles = 8'h14;
    fuses = fuse_bits_s'($random(seed));
    pg = (14 - WB + 1)'($random(seed));
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    cyc;
    // every pointer, lpm at each allowed delay
    for (i = 0; i < 5; i++) begin
      wr_ctrl(8'h09);
      repeat (i % 3) cyc;
      exp_q.push_back({8'h00, fuse_exp(i)});
      lpm(16'(i));
      cyc;
      check(16'(status), 16'h0000);
    end
    // late lpm returns no fuse byte
    wr_ctrl(8'h09);
    repeat (3) cyc;
    lpm(16'h0001);
    cyc;
    check(16'(status), 16'h0000);
    // An unarmed lpm must give no fuse pulse; the watcher holds no note for one.
    lpm(16'h0000);
    wr_ctrl(8'h03);
    repeat (4) cyc;
    spm({pg, 3'h0}, 16'h1234);
    cyc;
    check(16'(status | core_stall), 16'h0000);
    // reverse-order loads, spm up to three cycles late
    // Each word location is loaded only once between clears.
    for (i = 3; i >= 0; i--) begin
      w[i] = 16'($random(seed));
      load(i, w[i], 3 - i);
      if (i == 2) bufchk(0, BUF_ERASED);
    end
    for (i = 0; i < 4; i++) bufchk(i, w[i]);
    // erase with stray low pointer bits, slow flash
    wr_ctrl(8'h03);
    exp_q.push_back({2'b00, 1'b1, pg});
    spm({pg, 3'h5}, 16'($random(seed)));
    repeat (20) cyc;
    check(16'(core_stall), 16'h0001);
    wait_idle;
    // page write, prompt flash, buffer cleared after
    busy_cycles = 8'h00;
    wr_ctrl(8'h05);
    exp_q.push_back({2'b00, 1'b0, pg});
    spm({pg, 3'h0}, 16'($random(seed)));
    check(16'(core_stall), 16'h0001);
    wait_idle;
    for (i = 0; i < 4; i++) bufchk(i, BUF_ERASED);
    load(1, 16'h5A5A, 0);
    wr_ctrl(8'h11);
    bufchk(1, BUF_ERASED);
    check(16'(status), 16'h0000);
    // data memory write drops loads and blocks arming
    // Busy is clear at every other control write; this probe breaks it on purpose.
    load(2, 16'hA5A5, 1);
    data_mem_write_busy_bit = 1'b1;
    wr_ctrl(8'h03);
    data_mem_write_busy_bit = 1'b0;
    check(16'(status), 16'h0000);
    bufchk(2, BUF_ERASED);
    // ready interrupt, masked bits read zero
    global_irq_en = 1'b1;
    wr_ctrl(8'hE0);
    check(16'(status), 16'h0080);
    cyc;
    check(16'(prog_ready_irq), 16'h0001);
    data_mem_write_busy_bit = 1'b1;
    cyc;
    cyc;
    check(16'(prog_ready_irq), 16'h0000);
    data_mem_write_busy_bit = 1'b0;
    wr_ctrl(8'h81);
    cyc;
    check(16'(prog_ready_irq), 16'h0000);
    repeat (4) cyc;
    check(16'(status), 16'h0080);
    check(16'(exp_q.size()), 16'h0000);
    print_verdict;
  end
endmodule
